// [rtl/tmrc_top.sv]
`timescale 1ns/1ps
`include "tmrc_regs.svh"

// How it works
// - eight-bit readable writable counter wraps to zero
// - clock source clear: count instruction cycles
// - count write blocks increments two cycles
// - clock source set: count external pin edges
// - edge select: clear rising, set falling
// - rollover sets overflow flag, bit two
// - enable bit five clear masks request
// - sleep stops the timer, no wake
// - prescaler owned by counter or watchdog
// - prescaler is hidden eight-bit divider
// - assign bit, rate bits: 1:2 to 1:256 for the counter, 1:1 to 1:128 for the watchdog
// - count write clears prescaler when the counter owns it, keeps owner
module tmrc_top
    import tmrc_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 8,
    parameter int TCY_CYCLES     = `TMRC_TCY_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // external pulse source
    input  wire logic        external_count_input,
    // core power state
    input  wire logic        sleep_mode,
    // watchdog side of the shared prescaler
    input  wire logic        watchdog_timer_tick,
    input  wire logic        watchdog_timer_clear,
    output logic             watchdog_timer_tick_out,
    // interrupt request
    output logic             irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    tmrc_byte_t      count_register_reg;     // the counter itself
    tmrc_byte_t      option_reg;             // source, edge, owner, rate
    tmrc_byte_t      interrupt_control_reg;  // enables and overflow flag
    tmrc_inh_e       inh_state_reg;          // increment inhibit state
    tmrc_inh_e       inh_state_next;         // its next value
    logic [7:0]      tcy_div_reg;            // instruction cycle divider
    logic            tcy_en_reg;             // one pulse per instruction cycle
    logic            ext_prev_reg;           // last sample of the count pin
    logic            ext_rise;               // low to high on the pin
    logic            ext_fall;               // high to low on the pin
    logic            source_tick;            // raw tick from selected source
    logic            presc_in;               // tick fed to the prescaler
    logic            presc_out;              // divided tick
    logic            presc_clear;            // prescaler count clear
    logic            count_tick;             // tick that reaches the counter
    logic            count_inc;              // counter really increments
    logic            overflow;               // rollover this cycle
    tmrc_owner_e     owner;                  // prescaler owner
    logic            clock_source_select;    // external pin when set
    logic            source_edge_select;     // falling edge when set
    logic            prescaler_assign;       // watchdog owns prescaler when set
    logic [2:0]      prescale_rate;          // ratio code
    logic            overflow_flag;          // sticky rollover flag
    logic            overflow_int_enable;    // flag may raise the request
    logic            apb_setup;              // setup cycle of a transfer
    logic            apb_access;             // completing access cycle
    logic            wr_ok;                  // write to a mapped register
    logic            wr_count;               // write hits the counter
    logic            wr_option;              // write hits the option register
    logic            wr_intctl;              // write hits interrupt control

    // ------------------------------------------------------------------
    // address decode, used by the error answer
    // ------------------------------------------------------------------
    function automatic logic addr_known(input logic [11:0] a);
        return (a == `TMRC_ADDR_COUNT) || (a == `TMRC_ADDR_OPTION) || (a == `TMRC_ADDR_INTCTL);
    endfunction

    // ------------------------------------------------------------------
    // field views of the option and interrupt control registers
    // ------------------------------------------------------------------
    assign clock_source_select = option_reg[`TMRC_OPT_CSS];
    assign source_edge_select  = option_reg[`TMRC_OPT_SES];
    assign prescaler_assign    = option_reg[`TMRC_OPT_PSA];
    assign prescale_rate       = option_reg[`TMRC_OPT_RATE_MSB:`TMRC_OPT_RATE_LSB];
    assign overflow_flag       = interrupt_control_reg[`TMRC_INT_FLAG];
    assign overflow_int_enable = interrupt_control_reg[`TMRC_INT_EN];

    // ------------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------------
    // setup cycle: request presented, answer prepared
    assign apb_setup  = psel & ~penable;
    // access cycle: pready is already high, so this edge completes it
    assign apb_access = psel & penable & pready;
    // writes land only on a mapped register
    assign wr_ok      = apb_access & pwrite & ~pslverr;
    assign wr_count   = wr_ok & (paddr == `TMRC_ADDR_COUNT);
    assign wr_option  = wr_ok & (paddr == `TMRC_ADDR_OPTION);
    assign wr_intctl  = wr_ok & (paddr == `TMRC_ADDR_INTCTL);

    // ------------------------------------------------------------------
    // apb answer: one setup and one access cycle, no wait states
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready and error stand for the access cycle only
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_known(paddr);
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            case (paddr)
                `TMRC_ADDR_COUNT:  prdata <= {24'h00_0000, count_register_reg};
                `TMRC_ADDR_OPTION: prdata <= {24'h00_0000, option_reg};
                `TMRC_ADDR_INTCTL: prdata <= {24'h00_0000, interrupt_control_reg};
                // unmapped reads return zero
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // instruction cycle enable; held still during sleep
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcy_div_reg <= 8'h00;
            tcy_en_reg  <= 1'b0;
        end else if (sleep_mode) begin
            tcy_en_reg  <= 1'b0;
        end else if (tcy_div_reg == 8'(TCY_CYCLES - 1)) begin
            // last clock of the cycle: pulse and restart
            tcy_div_reg <= 8'h00;
            tcy_en_reg  <= 1'b1;
        end else begin
            tcy_div_reg <= tcy_div_reg + 8'h01;
            tcy_en_reg  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // count pin edge detection; the pin is synchronous to pclk
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= external_count_input;
        end
    end

    // edges seen between two consecutive samples
    assign ext_rise = external_count_input & ~ext_prev_reg;
    assign ext_fall = ~external_count_input & ext_prev_reg;

    // ------------------------------------------------------------------
    // source select and prescaler routing
    // ------------------------------------------------------------------
    always_comb begin
        source_tick = 1'b0;
        if (sleep_mode) begin
            source_tick = 1'b0;
        end else if (clock_source_select) begin
            source_tick = source_edge_select ? ext_fall : ext_rise;
        end else begin
            source_tick = tcy_en_reg;
        end
    end

    assign owner       = prescaler_assign ? TMRC_OWNER_WATCHDOG : TMRC_OWNER_COUNTER;
    // the owner's ticks go through the divider, the other bypasses it
    assign presc_in    = (owner == TMRC_OWNER_COUNTER) ? source_tick : watchdog_timer_tick;
    assign count_tick  = (owner == TMRC_OWNER_COUNTER) ? presc_out : source_tick;
    assign presc_clear = ((owner == TMRC_OWNER_COUNTER) && wr_count) ||
                         ((owner == TMRC_OWNER_WATCHDOG) && watchdog_timer_clear);

    // shared divider
    tmrc_prescaler #(
        .WIDTH     (PRESCALE_WIDTH)
    ) u_prescaler (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick_in   (presc_in),
        .clear_cnt (presc_clear),
        .rate      (prescale_rate),
        .owner     (owner),
        .tick_out  (presc_out)
    );

    // watchdog tick, divided or not, registered for the output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_timer_tick_out <= 1'b0;
        end else begin
            watchdog_timer_tick_out <= (owner == TMRC_OWNER_WATCHDOG) ? presc_out : watchdog_timer_tick;
        end
    end

    // ------------------------------------------------------------------
    // increment inhibit after a counter write
    // ------------------------------------------------------------------
    always_comb begin
        inh_state_next = inh_state_reg;
        if (wr_count) begin
            inh_state_next = TMRC_INH_TWO;
        end else if (tcy_en_reg) begin
            case (inh_state_reg)
                TMRC_INH_TWO:  inh_state_next = TMRC_INH_ONE;
                TMRC_INH_ONE:  inh_state_next = TMRC_INH_IDLE;
                TMRC_INH_IDLE: inh_state_next = TMRC_INH_IDLE;
                default:       inh_state_next = TMRC_INH_IDLE;
            endcase
        end
    end

    // inhibit state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_state_reg <= TMRC_INH_IDLE;
        end else begin
            inh_state_reg <= inh_state_next;
        end
    end

    assign count_inc = count_tick & (inh_state_reg == TMRC_INH_IDLE) & ~wr_count;
    assign overflow  = count_inc & (count_register_reg == 8'hFF);

    // ------------------------------------------------------------------
    // counter; a software write wins over a tick
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_register_reg <= `TMRC_CNT_RESET;
        end else if (wr_count) begin
            count_register_reg <= pwdata[7:0];
        end else if (count_inc) begin
            count_register_reg <= count_register_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // option register: source, edge, owner and rate
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg <= `TMRC_OPT_RESET;
        end else if (wr_option) begin
            option_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupt control: plain bits plus the sticky overflow flag
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control_reg <= `TMRC_INT_RESET;
        end else begin
            if (wr_intctl) begin
                // every bit but the flag is plain read/write
                interrupt_control_reg[7:3] <= pwdata[7:3];
                interrupt_control_reg[1:0] <= pwdata[1:0];
            end
            if (overflow) begin
                interrupt_control_reg[`TMRC_INT_FLAG] <= 1'b1;
            end else if (wr_intctl && pwdata[`TMRC_INT_FLAG]) begin
                interrupt_control_reg[`TMRC_INT_FLAG] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt request, registered
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= overflow_flag & overflow_int_enable;
        end
    end

endmodule

// [rtl/tmrc_regs.svh]
`ifndef TMRC_REGS_SVH
`define TMRC_REGS_SVH

// register indices; the byte address is four times the index
`define TMRC_IDX_COUNT       10'h001
`define TMRC_IDX_OPTION      10'h081
`define TMRC_IDX_INTCTL      10'h00B
`define TMRC_ADDR_COUNT      {`TMRC_IDX_COUNT, 2'b00}
`define TMRC_ADDR_OPTION     {`TMRC_IDX_OPTION, 2'b00}
`define TMRC_ADDR_INTCTL     {`TMRC_IDX_INTCTL, 2'b00}

// option register fields
`define TMRC_OPT_CSS         5
`define TMRC_OPT_SES         4
`define TMRC_OPT_PSA         3
`define TMRC_OPT_RATE_MSB    2
`define TMRC_OPT_RATE_LSB    0

// interrupt control fields
`define TMRC_INT_GIE         7
`define TMRC_INT_EN          5
`define TMRC_INT_FLAG        2

// reset values
`define TMRC_CNT_RESET       8'h00
`define TMRC_OPT_RESET       8'hFF
`define TMRC_INT_RESET       8'h00

// timing: clock rate, instruction cycle time and derived counts
`define TMRC_CLK_MHZ         10
`define TMRC_TCY_NS          400
`define TMRC_TCY_CYCLES      ((`TMRC_TCY_NS * `TMRC_CLK_MHZ) / 1000)
`define TMRC_INHIBIT_TCY     2

`endif

// [rtl/tmrc_pkg.sv]
package tmrc_pkg;

    // one register byte
    typedef logic [7:0] tmrc_byte_t;

    // owner of the shared prescaler
    typedef enum logic {
        TMRC_OWNER_COUNTER,
        TMRC_OWNER_WATCHDOG
    } tmrc_owner_e;

    // increment inhibit sequence after a count write
    typedef enum logic [1:0] {
        TMRC_INH_IDLE,
        TMRC_INH_ONE,
        TMRC_INH_TWO
    } tmrc_inh_e;

endpackage

// [rtl/tmrc_prescaler.sv]
`timescale 1ns/1ps

// shared divider, counts input ticks and emits one tick per ratio period
module tmrc_prescaler
    import tmrc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        tick_in,
    input  wire logic        clear_cnt,
    input  wire logic [2:0]  rate,
    input  tmrc_owner_e      owner,
    // divided tick
    output logic             tick_out
);

    logic [WIDTH-1:0] count_reg;   // divider count, invisible to software
    logic [WIDTH-1:0] tap_mask;    // low bits that must all be set

    // low bits that must be ones; counter owner starts at 1:2, watchdog at 1:1
    function automatic logic [WIDTH-1:0] mask_of(input logic [2:0] r, input tmrc_owner_e o);
        logic [WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (o == TMRC_OWNER_WATCHDOG) begin
                m[i] = (i < int'(r));
            end else begin
                m[i] = (i <= int'(r));
            end
        end
        return m;
    endfunction

    // ratio taps
    assign tap_mask = mask_of(rate, owner);
    assign tick_out = tick_in & ((count_reg & tap_mask) == tap_mask);

    // divider count; a clear wins over a tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (clear_cnt) begin
            count_reg <= '0;
        end else if (tick_in) begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule

// [tb/tmrc_properties.sv]
`timescale 1ns/1ps
`include "tmrc_regs.svh"

// watches the apb side, irq and watchdog tick path of the timer block
module tmrc_properties
    import tmrc_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 8,
    parameter int TCY_CYCLES     = 4
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and power state
    input wire logic        external_count_input,
    input wire logic        sleep_mode,
    // watchdog side
    input wire logic        watchdog_timer_tick,
    input wire logic        watchdog_timer_clear,
    input wire logic        watchdog_timer_tick_out,
    // interrupt request
    input wire logic        irq
);
    logic       setup;   // apb setup cycle
    logic       acc_wr;  // completed write
    logic       rd_ok;   // completed good read
    logic       mapped;  // address hits a register
    logic [7:0] opt_sh;  // shadow of the option register
    logic       en_sh;   // shadow of the overflow enable

    assign setup  = psel && !penable;
    assign acc_wr = psel && penable && pready && pwrite && !pslverr;
    assign rd_ok  = pready && !pwrite && !pslverr;
    assign mapped = (paddr == `TMRC_ADDR_COUNT) || (paddr == `TMRC_ADDR_OPTION) || (paddr == `TMRC_ADDR_INTCTL);

    // shadow option and enable from completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_sh <= `TMRC_OPT_RESET;
            en_sh  <= 1'b0;
        end else if (acc_wr && paddr == `TMRC_ADDR_OPTION) begin
            opt_sh <= pwdata[7:0];
        end else if (acc_wr && paddr == `TMRC_ADDR_INTCTL) begin
            en_sh <= pwdata[`TMRC_INT_EN];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY: assert property (setup |=> pready)
        else $error("pready missing after setup");
    AST_ONLY_ACCESS: assert property (pready |-> psel && penable && $past(setup))
        else $error("pready outside an access cycle");
    AST_SLVERR: assert property (setup |=> (pslverr != $past(mapped)))
        else $error("pslverr does not follow the address map");
    AST_RDATA: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000 && (!pslverr || prdata[7:0] == 8'h00))
        else $error("read data upper bits or refused data not zero");
    AST_OPT_READ: assert property (rd_ok && paddr == `TMRC_ADDR_OPTION |-> prdata[7:0] == opt_sh)
        else $error("option read differs from last write");
    AST_IRQ_MATCH: assert property (rd_ok && paddr == `TMRC_ADDR_INTCTL |-> irq == (prdata[5] && prdata[2]))
        else $error("irq differs from flag and enable");
    AST_IRQ_MASK: assert property (!en_sh && !$past(en_sh) |-> !irq)
        else $error("irq high while overflow enable clear");
    AST_SLEEP: assert property ((sleep_mode && !psel) [*4] |=> $stable(irq))
        else $error("irq moved during sleep");
    AST_WDT_DIRECT: assert property (!$past(opt_sh[3]) |-> watchdog_timer_tick_out == $past(watchdog_timer_tick))
        else $error("watchdog tick divided while counter owns prescaler");

    COV_IRQ: cover property ($rose(irq));
    COV_ERR: cover property (pready && pslverr);
    COV_SLEEP: cover property (sleep_mode [*4]);
    COV_WDT: cover property (watchdog_timer_tick_out);
endmodule

bind tmrc_top tmrc_properties #(
    .PRESCALE_WIDTH (PRESCALE_WIDTH),
    .TCY_CYCLES     (TCY_CYCLES)
) tmrc_properties_i (
    .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
    .pready (pready), .pslverr (pslverr), .external_count_input (external_count_input),
    .sleep_mode (sleep_mode), .watchdog_timer_tick (watchdog_timer_tick),
    .watchdog_timer_clear (watchdog_timer_clear),
    .watchdog_timer_tick_out (watchdog_timer_tick_out), .irq (irq)
);

// [tb/tmrc_pulse_src.sv]
`timescale 1ns/1ps

// far-side pulse source: toggles the count pin a set number of times
module tmrc_pulse_src
    import tmrc_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // request from the bench
    input  wire logic       start,
    input  wire logic [5:0] toggles,
    input  wire logic [3:0] half,
    // pin and status
    output logic            pin,
    output logic            busy
);
    logic [5:0] left_reg; // toggles still to make
    logic [3:0] hold_reg; // cycles left at this level

    // each level held half cycles, at least two, so the sampler sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin      <= 1'b0;
            busy     <= 1'b0;
            left_reg <= 6'h00;
            hold_reg <= 4'h0;
        end else if (start && !busy) begin
            busy     <= 1'b1;
            left_reg <= toggles;
            hold_reg <= half;
        end else if (busy && hold_reg > 4'h1) begin
            hold_reg <= hold_reg - 4'h1;
        end else if (busy) begin
            pin      <= ~pin;
            hold_reg <= half;
            left_reg <= left_reg - 6'h01;
            busy     <= (left_reg != 6'h01);
        end
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "tmrc_regs.svh"

// self-checking bench with an integer model of the timer
module tb_top;
    localparam int TCY = `TMRC_TCY_CYCLES; // pclk cycles per tick
    // design signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        external_count_input;
    logic        sleep_mode;
    logic        watchdog_timer_tick;
    logic        watchdog_timer_clear;
    logic        watchdog_timer_tick_out;
    logic        irq;
    // pulse source control
    logic        src_start;
    logic [5:0]  src_toggles;
    logic        src_busy;
    // counters and model state
    int          n_errors;
    int          checks;
    int          cyc;
    int          m_opt;
    int          m_int;
    int          m_pin;
    int          t;
    int          d;
    logic [31:0] rdat;
    logic [31:0] rd_a;
    logic        err;

    tmrc_top #(.PRESCALE_WIDTH (8), .TCY_CYCLES (TCY)) tmrc_top_i (
        .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
        .pready (pready), .pslverr (pslverr), .external_count_input (external_count_input),
        .sleep_mode (sleep_mode), .watchdog_timer_tick (watchdog_timer_tick),
        .watchdog_timer_clear (watchdog_timer_clear),
        .watchdog_timer_tick_out (watchdog_timer_tick_out), .irq (irq)
    );
    tmrc_pulse_src tmrc_pulse_src_i (
        .pclk (pclk), .presetn (presetn), .start (src_start), .toggles (src_toggles),
        .half (4'h3), .pin (external_count_input), .busy (src_busy)
    );

    // clock
    always #50 pclk = ~pclk;

    // random watchdog ticks and the hang limit
    always @(posedge pclk) begin
        watchdog_timer_tick <= presetn && ($urandom_range(0, 3) == 0);
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    // one apb transfer; request held until pready, released by idle
    task automatic apb(input logic [11:0] a, input logic w, input int wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
    endtask

    // release the bus and let k edges pass
    task automatic idle(input int k);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (k) @(posedge pclk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdc(input logic [11:0] a, input string what, input int exp);
        apb(a, 1'b0, 0);
        chk(what, exp, rdat);
    endtask

    // two count reads span edges apart must differ by n
    task automatic diff_chk(input string what, input int span, input int n);
        apb(`TMRC_ADDR_COUNT, 1'b0, 0);
        rd_a = rdat;
        idle(span - 2);
        rdc(`TMRC_ADDR_COUNT, what, (rd_a + n) & 8'hFF);
    endtask

    // model of an interrupt control write, flag is write-one-to-clear
    function automatic int int_wr(input int old, input int wd);
        return (wd & 8'hFB) | (old & ~wd & 8'h04);
    endfunction

    task automatic test_done();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h29a0));
        {pclk, presetn, psel, penable, pwrite, sleep_mode, src_start} = 7'h00;
        {watchdog_timer_clear, paddr, pwdata, src_toggles} = '0;
        {n_errors, checks, m_pin, m_int} = '0;
        m_opt = `TMRC_OPT_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and a refused address
        rdc(`TMRC_ADDR_COUNT, "count reset", `TMRC_CNT_RESET);
        rdc(`TMRC_ADDR_OPTION, "option reset", m_opt);
        rdc(`TMRC_ADDR_INTCTL, "intctl reset", m_int);
        rdc(12'h000, "unmapped data", 0);
        chk("unmapped err", 1, 32'(err));
        // timer mode: write inhibit then plain rate
        m_opt = 8'h08;
        apb(`TMRC_ADDR_OPTION, 1'b1, m_opt);
        d = $urandom_range(0, 150);
        apb(`TMRC_ADDR_COUNT, 1'b1, d);
        rdc(`TMRC_ADDR_COUNT, "count written", d);
        idle(TCY * 10 - 2);
        rdc(`TMRC_ADDR_COUNT, "count inhibit", d + 8);
        diff_chk("timer rate", TCY * 10, 10);
        // sleep freezes the count
        sleep_mode <= 1'b1;
        idle(4);
        diff_chk("sleep", TCY * 10, 0);
        sleep_mode <= 1'b0;
        // every prescale code while the counter owns it
        for (int r = 0; r < 8; r++) begin
            apb(`TMRC_ADDR_OPTION, 1'b1, r);
            rdc(`TMRC_ADDR_OPTION, "option rate", r);
            diff_chk("prescaled", TCY << (r + 2), 2);
        end
        // counter mode, rising then falling edges
        for (int e = 0; e < 2; e++) begin
            apb(`TMRC_ADDR_OPTION, 1'b1, 8'h28 | (e << 4));
            apb(`TMRC_ADDR_COUNT, 1'b0, 0);
            rd_a = rdat;
            idle(1);
            t = $urandom_range(3, 9);
            src_toggles <= t;
            src_start   <= 1'b1;
            @(posedge pclk);
            src_start <= 1'b0;
            @(posedge pclk);
            while (src_busy) @(posedge pclk);
            idle(8);
            d = (m_pin == 0) ? (t + 1) / 2 : t / 2;
            d = e ? t - d : d;
            m_pin = m_pin ^ (t & 1);
            rdc(`TMRC_ADDR_COUNT, "pin edges", (rd_a + d) & 8'hFF);
        end
        // overflow, mask, sticky flag, clear
        apb(`TMRC_ADDR_OPTION, 1'b1, 8'h08);
        m_int = int_wr(m_int, 8'h20);
        apb(`TMRC_ADDR_INTCTL, 1'b1, 8'h20);
        apb(`TMRC_ADDR_COUNT, 1'b1, 8'hFE);
        idle(TCY * 6);
        rdc(`TMRC_ADDR_COUNT, "wrap", 8'h02);
        m_int = m_int | 8'h04;
        rdc(`TMRC_ADDR_INTCTL, "flag set", m_int);
        chk("irq set", 1, 32'(irq));
        m_int = int_wr(m_int, 8'h00);
        apb(`TMRC_ADDR_INTCTL, 1'b1, 8'h00);
        idle(3);
        chk("irq masked", 0, 32'(irq));
        rdc(`TMRC_ADDR_INTCTL, "flag kept", m_int);
        m_int = int_wr(m_int, 8'h24);
        apb(`TMRC_ADDR_INTCTL, 1'b1, 8'h24);
        idle(3);
        chk("irq cleared", 0, 32'(irq));
        rdc(`TMRC_ADDR_INTCTL, "flag cleared", m_int);
        idle(2);
        test_done();
    end
endmodule
